// [hw/memspace_decode.sv]
// data-space decoder, access timing, program counter and register space
// assumes a cpu load/store unit that waits for done and honours req_ready
`timescale 1ns/1ps
`include "memspace_defines.svh"
module memspace_decode
  import memspace_pkg::*;
#(
  parameter int          NVM_WRITE_CLKS = `NVM_WRITE_CLKS,
  parameter logic [12:0] BOOT_START     = `BOOT_START
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // configuration
  input  wire logic        legacy_mode,
  input  wire logic [1:0]  wait_states,
  output logic             external_memory_enable,
  // program store control
  input  wire logic        pc_advance,
  input  wire logic        pc_two_word,
  input  wire logic        pc_load,
  input  wire logic [12:0] pc_target,
  input  wire logic        boot_lock,
  input  wire logic        app_lock,
  input  wire logic        prog_wr_req,
  input  wire logic [12:0] prog_wr_addr,
  output logic      [12:0] program_counter,
  output logic             pc_in_boot,
  output logic             prog_wr_allowed,
  // cpu data request
  input  wire logic        req_valid,
  input  wire req_t        req,
  input  wire logic [15:0] ptr_x,
  input  wire logic [15:0] ptr_y,
  input  wire logic [15:0] ptr_z,
  output logic             req_ready,
  output logic             done,
  output logic      [7:0]  rdata,
  output logic             cpu_stall,
  // pointer write-back
  output logic             ptr_wb_valid,
  output ptr_sel_t         ptr_wb_sel,
  output logic      [15:0] ptr_wb_value,
  // register file and peripheral registers
  output region_t          periph_region,
  output logic      [7:0]  periph_addr,
  output logic      [7:0]  periph_wdata,
  output logic             periph_we,
  output logic             periph_re,
  input  wire logic [7:0]  periph_rdata,
  // external sram
  output logic      [15:0] ext_addr,
  output logic      [7:0]  ext_wdata,
  input  wire logic [7:0]  ext_rdata,
  output logic             external_read_strobe_pin_n,
  output logic             external_write_strobe_pin_n
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  st_t         q;
  st_t         d;
  logic [7:0]  sram [0:1023];
  logic [15:0] ptr_val;
  logic [15:0] ptr_next;
  logic [15:0] eff_addr;
  logic [15:0] map_addr;
  logic [15:0] sram_off;
  logic [15:0] io_off;
  logic [5:0]  io_idx;
  logic [5:0]  disp;
  logic [3:0]  extra;
  region_t     new_region;
  logic        take;
  logic        fin;
  logic        ext_act;
  logic        mcu_hit;
  logic        nvm_hit_raw;
  logic        nvm_hit;
  logic        int_reg;
  logic        nvm_wr;
  logic        nvm_stall;
  logic [7:0]  nvm_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // address map

  function automatic region_t decode(input logic [15:0] a, input logic leg, input logic xen);
    region_t r;
    if (a < `MS_IO_BASE) r = RG_RF;
    else if (a < `MS_XIO_BASE) r = RG_IO;
    else if (!leg && a < `MS_SRAM_NATIVE) r = RG_XIO;
    else if (a < (leg ? `MS_TOP_LEGACY : `MS_TOP_NATIVE)) r = RG_SRAM;
    else if (xen) r = RG_EXT;
    else r = RG_NONE;
    return r;
  endfunction

  assign external_memory_enable = q.mcu_control_register[`MCU_CTRL_XMEM_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // effective address

  // entries 26..31 arrive as three 16-bit pointers from the register file
  always_comb begin
    unique case (req.ptr)
      PTR_X:   ptr_val = ptr_x;
      PTR_Y:   ptr_val = ptr_y;
      PTR_Z:   ptr_val = ptr_z;
      default: ptr_val = 16'h0000;
    endcase
  end

  // x has no displacement form
  assign disp = (req.ptr == PTR_X) ? 6'h00 : req.disp;

  always_comb begin
    eff_addr = ptr_val;
    ptr_next = ptr_val;
    unique case (req.mode)
      AM_DIRECT:   eff_addr = req.addr;
      AM_INDIRECT: eff_addr = ptr_val;
      AM_DISP:     eff_addr = ptr_val + {10'h000, disp};
      AM_PREDEC: begin
        eff_addr = ptr_val - 16'h0001;
        ptr_next = ptr_val - 16'h0001;
      end
      AM_POSTINC: begin
        eff_addr = ptr_val;
        ptr_next = ptr_val + 16'h0001;
      end
      default: eff_addr = req.addr;
    endcase
  end

  // short forms carry six bits, so they can never reach extended I/O
  assign map_addr   = req.short_io ? (`MS_IO_BASE + {10'h000, req.addr[5:0]}) : eff_addr;
  assign new_region = decode(map_addr, legacy_mode, external_memory_enable);
  assign sram_off   = map_addr - (legacy_mode ? `MS_SRAM_LEGACY : `MS_SRAM_NATIVE);

  always_comb begin
    extra = 4'h0;
    if (new_region == RG_EXT) begin
      unique case (req.kind)
        K_BYTE:       extra = `EXT_BYTE_EXTRA + {2'b00, wait_states};
        K_FRAME_HEAD: extra = `EXT_FRAME_EXTRA + {1'b0, wait_states, 1'b0};
        K_FRAME_TAIL: extra = 4'h0;
        default:      extra = `EXT_BYTE_EXTRA + {2'b00, wait_states};
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // access sequencing

  assign req_ready = q.fsm == S_IDLE && !nvm_stall;
  assign take      = ce && req_valid && req_ready;
  assign fin       = ce && q.fsm == S_BUSY && q.cnt == 4'h0;
  assign cpu_stall = nvm_stall;

  assign io_off  = q.acc.addr - `MS_IO_BASE;
  assign io_idx  = io_off[5:0];
  assign mcu_hit = q.acc.region == RG_IO && io_idx == `MCU_CTRL_IO;
  assign nvm_hit = q.acc.region == RG_IO && nvm_hit_raw;
  assign int_reg = mcu_hit || nvm_hit;
  assign nvm_wr  = fin && q.acc.write && nvm_hit;

  always_comb begin
    d      = q;
    d.done = 1'b0;
    if (pc_load) d.pc = pc_target;
    else if (pc_advance) d.pc = q.pc + (pc_two_word ? 13'h0002 : 13'h0001);
    unique case (q.fsm)
      S_IDLE: begin
        if (req_valid && !nvm_stall) begin
          d.fsm        = S_BUSY;
          d.cnt        = extra;
          d.acc.write  = req.write;
          d.acc.region = new_region;
          d.acc.addr   = map_addr;
          d.acc.wdata  = req.wdata;
          d.acc.sidx   = sram_off[9:0];
          d.wb_sel     = req.ptr;
          d.wb_value   = ptr_next;
          d.wb_valid   = req.mode inside {AM_PREDEC, AM_POSTINC} && !req.short_io;
        end
      end
      S_BUSY: begin
        if (q.cnt != 4'h0) begin
          d.cnt = q.cnt - 4'h1;
        end else begin
          d.fsm  = S_IDLE;
          d.done = 1'b1;
          if (q.acc.write && mcu_hit) d.mcu_control_register = q.acc.wdata;
          if (!q.acc.write) begin
            unique case (q.acc.region)
              RG_SRAM: d.rdata = sram[q.acc.sidx];
              RG_EXT:  d.rdata = ext_rdata;
              RG_NONE: d.rdata = 8'h00;
              default: d.rdata = mcu_hit ? q.mcu_control_register : (nvm_hit ? nvm_rdata : periph_rdata);
            endcase
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (fin && q.acc.write && q.acc.region == RG_SRAM) sram[q.acc.sidx] <= q.acc.wdata;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q       <= '0;
      q.fsm   <= S_IDLE;
      q.mcu_control_register <= `MCU_CTRL_RESET;
    end else if (ce) begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign done            = q.done;
  assign rdata           = q.rdata;
  assign ptr_wb_valid    = q.done && q.wb_valid;
  assign ptr_wb_sel      = q.wb_sel;
  assign ptr_wb_value    = q.wb_value;
  assign program_counter = q.pc;
  assign pc_in_boot      = q.pc >= BOOT_START;
  assign prog_wr_allowed = prog_wr_req && !(prog_wr_addr >= BOOT_START ? boot_lock : app_lock);

  assign periph_region = q.acc.region;
  assign periph_addr   = q.acc.addr[7:0];
  assign periph_wdata  = q.acc.wdata;
  assign periph_we     = fin && q.acc.write && !int_reg &&
                         q.acc.region inside {RG_RF, RG_IO, RG_XIO};
  assign periph_re     = fin && !q.acc.write && !int_reg &&
                         q.acc.region inside {RG_RF, RG_IO, RG_XIO};

  // strobes follow the external region only, so internal cycles stay quiet
  assign ext_act                     = q.fsm == S_BUSY && q.acc.region == RG_EXT;
  assign ext_addr                    = q.acc.addr;
  assign ext_wdata                   = q.acc.wdata;
  assign external_read_strobe_pin_n  = !(ext_act && !q.acc.write);
  assign external_write_strobe_pin_n = !(ext_act && q.acc.write);

  nvm_port #(
    .WRITE_CLKS (NVM_WRITE_CLKS)
  ) u_nvm (
    .clk        (clk),
    .rst        (rst),
    .ce         (ce),
    .io_wr      (nvm_wr),
    .io_idx     (io_idx),
    .io_wdata   (q.acc.wdata),
    .io_rdata   (nvm_rdata),
    .io_hit     (nvm_hit_raw),
    .stall      (nvm_stall),
    .write_busy ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_take_int;
    take && new_region != RG_EXT;
  endsequence

  sequence s_take_ext_byte;
    take && new_region == RG_EXT && req.kind == K_BYTE;
  endsequence

  property p_int_two;
    @(posedge clk) disable iff (rst) s_take_int ##1 ce |-> fin ##1 done;
  endproperty
  a_int_two: assert property (p_int_two) else $error("internal access not two cycles");

  property p_ext_ws0;
    @(posedge clk) disable iff (rst)
      (s_take_ext_byte and wait_states == 2'h0) ##1 ce[*2] |-> !done ##1 done;
  endproperty
  a_ext_ws0: assert property (p_ext_ws0) else $error("external access not three cycles");

  property p_ext_ws_bytes;
    @(posedge clk) disable iff (rst)
      s_take_ext_byte |=> q.cnt == 4'h1 + {2'b00, $past(wait_states)};
  endproperty
  a_ext_ws_bytes: assert property (p_ext_ws_bytes) else $error("byte wait stretch wrong");

  property p_frame;
    @(posedge clk) disable iff (rst)
      (take && new_region == RG_EXT && req.kind == K_FRAME_HEAD)
      |=> q.cnt == 4'h3 + {1'b0, $past(wait_states), 1'b0};
  endproperty
  a_frame: assert property (p_frame) else $error("frame stretch wrong");

  property p_quiet_strobes;
    @(posedge clk) disable iff (rst)
      q.acc.region != RG_EXT |-> external_read_strobe_pin_n && external_write_strobe_pin_n;
  endproperty
  a_quiet_strobes: assert property (p_quiet_strobes) else $error("strobe on internal access");

  property p_legacy_no_xio;
    @(posedge clk) disable iff (rst) (take && legacy_mode) |=> q.acc.region != RG_XIO;
  endproperty
  a_legacy_no_xio: assert property (p_legacy_no_xio) else $error("extended io in legacy");

  property p_ext_enabled;
    @(posedge clk) disable iff (rst) take && new_region == RG_EXT |-> external_memory_enable;
  endproperty
  a_ext_enabled: assert property (p_ext_enabled) else $error("external without enable");

  property p_short_io;
    @(posedge clk) disable iff (rst)
      (take && req.short_io) |=> q.acc.region == RG_IO;
  endproperty
  a_short_io: assert property (p_short_io) else $error("short form left io space");

  property p_pc_step;
    @(posedge clk) disable iff (rst)
      (ce && pc_advance && !pc_load) |=> program_counter ==
        $past(program_counter) + ($past(pc_two_word) ? 13'h0002 : 13'h0001);
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("program counter step wrong");

  property p_post_wb;
    @(posedge clk) disable iff (rst)
      (take && req.mode == AM_POSTINC && !req.short_io)
      |=> ptr_wb_value == $past(ptr_val) + 16'h0001 && q.acc.addr == $past(ptr_val);
  endproperty
  a_post_wb: assert property (p_post_wb) else $error("post-increment value wrong");

  property p_predec;
    @(posedge clk) disable iff (rst)
      (take && req.mode == AM_PREDEC && !req.short_io)
      |=> q.acc.addr == $past(ptr_val) - 16'h0001 && ptr_wb_value == q.acc.addr;
  endproperty
  a_predec: assert property (p_predec) else $error("pre-decrement address wrong");

endmodule

// [hw/memspace_defines.svh]
// constants of the data-space decoder and the non-volatile byte store port
// assumes a 250 MHz cpu clock and a 1 MHz calibrated oscillator for timing
//
// Summary of operation
// - program store is 8K words of 16 bits; instructions use one or two words
// - program counter is 13 bits, counting words across all 8K locations
// - program store splits into boot and application sections, separately protected
// - native map: 32 register file, 64 standard I/O, 160 extended I/O, 1024 SRAM
// - legacy map: 96 register file and I/O, then 1024 SRAM, 1120 in all
// - legacy mode never decodes the extended I/O region as I/O
// - extended I/O is reachable only by data-space loads and stores, not short forms
// - external SRAM fills the 64K space right after the last internal location
// - addresses past internal locations go external with the same instructions
// - external read and write strobes stay inactive during internal accesses
// - external SRAM works only while the external memory enable bit is set
// - zero wait states: external byte access takes one extra cycle
// - external stack, zero waits: call, return, interrupt entry take three extra
// - 1/2/3 waits add 2/3/4 per byte and 5/7/9 per call frame
// - register entries 26 to 31 form three 16-bit pointer registers
// - displacement mode adds up to 63 to either upper pointer
// - pre-decrement before, post-increment after access, result written back
// - internal SRAM access completes in two cpu cycles
// - non-volatile store is a separate 512-byte space, byte wide, addresses 0-511
// - non-volatile read stalls the cpu four cycles
// - non-volatile write stalls the cpu two cycles
// - address bits 15 to 9 ignore writes and read zero; 8 to 0 hold address
// - byte address is undefined after reset; software loads it first
// - data register holds byte to write, and after a read the byte read
// - writes start only through the guarded two-step enable procedure
// - master enable self-clears after four cycles; write strobe works only while set
// - write strobe stays set for the whole write, cleared by hardware at end
// - read strobe fetches the addressed byte into the data register at once
// - write lasts 8448 cycles of the 1 MHz oscillator
`ifndef MEMSPACE_DEFINES_SVH
`define MEMSPACE_DEFINES_SVH

// data-space map
`define MS_IO_BASE        16'h0020
`define MS_XIO_BASE       16'h0060
`define MS_SRAM_NATIVE    16'h0100
`define MS_SRAM_LEGACY    16'h0060
`define MS_TOP_NATIVE     16'h0500
`define MS_TOP_LEGACY     16'h0460

// registers by I/O index
`define MCU_CTRL_IO       6'h35
`define MCU_CTRL_RESET    8'h00
`define MCU_CTRL_XMEM_BIT 7
`define NVM_CTRL_IO       6'h1C
`define NVM_DATA_IO       6'h1D
`define NVM_ADDRL_IO      6'h1E
`define NVM_ADDRH_IO      6'h1F
`define NVM_RE_BIT        0
`define NVM_WE_BIT        1
`define NVM_MWE_BIT       2

// program store
`define PC_W              13
`define BOOT_START        13'h1C00

// timing
`define EXT_BYTE_EXTRA    4'h1
`define EXT_FRAME_EXTRA   4'h3
`define NVM_READ_STALL    3'h4
`define NVM_WRITE_STALL   3'h2
`define NVM_MWE_WINDOW    3'h4
`define NVM_WRITE_OSC_CYC 8448
`define NVM_OSC_MHZ       1
`define CLK_MHZ           250
`define NVM_WRITE_CLKS    (`NVM_WRITE_OSC_CYC * `CLK_MHZ / `NVM_OSC_MHZ)

`endif

// [hw/memspace_pkg.sv]
// types shared by the decoder and the non-volatile port
// assumes nothing beyond the defines header
package memspace_pkg;

  typedef enum logic [1:0] {S_IDLE = 2'b01, S_BUSY = 2'b10} fsm_t;

  typedef enum logic [2:0] {
    RG_NONE = 3'h0, RG_RF = 3'h1, RG_IO = 3'h2, RG_XIO = 3'h3, RG_SRAM = 3'h4, RG_EXT = 3'h5
  } region_t;

  typedef enum logic [2:0] {
    AM_DIRECT = 3'h0, AM_INDIRECT = 3'h1, AM_DISP = 3'h2, AM_PREDEC = 3'h3, AM_POSTINC = 3'h4
  } addr_mode_t;

  typedef enum logic [1:0] {PTR_X = 2'h0, PTR_Y = 2'h1, PTR_Z = 2'h2} ptr_sel_t;

  typedef enum logic [1:0] {K_BYTE = 2'h0, K_FRAME_HEAD = 2'h1, K_FRAME_TAIL = 2'h2} kind_t;

  typedef struct packed {
    logic       write;
    logic       short_io;
    kind_t      kind;
    addr_mode_t mode;
    ptr_sel_t   ptr;
    logic [5:0] disp;
    logic [15:0] addr;
    logic [7:0] wdata;
  } req_t;

  typedef struct packed {
    logic       write;
    region_t    region;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [9:0] sidx;
  } acc_t;

  typedef struct packed {
    fsm_t        fsm;
    acc_t        acc;
    logic [3:0]  cnt;
    logic [7:0]  mcu_control_register;
    logic        done;
    logic [7:0]  rdata;
    logic        wb_valid;
    ptr_sel_t    wb_sel;
    logic [15:0] wb_value;
    logic [12:0] pc;
  } st_t;

  typedef struct packed {
    logic [8:0]  addr;
    logic [7:0]  data;
    logic        mwe;
    logic [2:0]  mwe_cnt;
    logic        we;
    logic [21:0] timer;
    logic [2:0]  stall_cnt;
  } nvm_st_t;

endpackage

// [hw/nvm_port.sv]
// cpu-side access port of the 512-byte non-volatile byte store
// assumes register writes arrive as one-cycle pulses from the decoder
`timescale 1ns/1ps
`include "memspace_defines.svh"
module nvm_port
  import memspace_pkg::*;
#(
  parameter int WRITE_CLKS = `NVM_WRITE_CLKS
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // register access
  input  wire logic       io_wr,
  input  wire logic [5:0] io_idx,
  input  wire logic [7:0] io_wdata,
  output logic      [7:0] io_rdata,
  output logic            io_hit,
  // status
  output logic            stall,
  output logic            write_busy
);

  nvm_st_t    q;
  nvm_st_t    d;
  logic [7:0] mem [0:511];
  logic       rd_go;
  logic       wr_go;

  assign io_hit     = io_idx inside {`NVM_CTRL_IO, `NVM_DATA_IO, `NVM_ADDRL_IO, `NVM_ADDRH_IO};
  assign stall      = q.stall_cnt != 3'h0;
  assign write_busy = q.we;
  // write strobe counts only while the master enable window is open; the read strobe needs no window
  assign wr_go = io_wr && io_idx == `NVM_CTRL_IO && io_wdata[`NVM_WE_BIT] && q.mwe && !q.we;
  assign rd_go = io_wr && io_idx == `NVM_CTRL_IO && io_wdata[`NVM_RE_BIT] && !q.we;

  always_comb begin
    unique case (io_idx)
      `NVM_CTRL_IO:  io_rdata = {5'h00, q.mwe, q.we, 1'b0};
      `NVM_DATA_IO:  io_rdata = q.data;
      `NVM_ADDRL_IO: io_rdata = q.addr[7:0];
      `NVM_ADDRH_IO: io_rdata = {7'h00, q.addr[8]};
      default:       io_rdata = 8'h00;
    endcase
  end

  always_comb begin
    d = q;
    if (q.stall_cnt != 3'h0) d.stall_cnt = q.stall_cnt - 3'h1;
    if (q.mwe) begin
      if (q.mwe_cnt == 3'h0) d.mwe = 1'b0;
      else d.mwe_cnt = q.mwe_cnt - 3'h1;
    end
    if (q.we) begin
      if (q.timer == 22'h0) d.we = 1'b0;
      else d.timer = q.timer - 22'h1;
    end
    if (io_wr && io_idx == `NVM_DATA_IO) d.data = io_wdata;
    if (io_wr && !q.we && io_idx == `NVM_ADDRL_IO) d.addr[7:0] = io_wdata;
    if (io_wr && !q.we && io_idx == `NVM_ADDRH_IO) d.addr[8] = io_wdata[0];
    if (io_wr && io_idx == `NVM_CTRL_IO && io_wdata[`NVM_MWE_BIT]) begin
      d.mwe     = 1'b1;
      d.mwe_cnt = `NVM_MWE_WINDOW - 3'h1;
    end
    if (wr_go) begin
      d.we        = 1'b1;
      d.timer     = 22'(WRITE_CLKS - 1);
      d.stall_cnt = `NVM_WRITE_STALL;
    end
    if (rd_go) begin
      d.data      = mem[q.addr];
      d.stall_cnt = `NVM_READ_STALL;
    end
  end

  // cell written at the strobe; the timer only paces the busy flag
  always_ff @(posedge clk) begin
    if (ce && !rst && wr_go) mem[q.addr] <= q.data;
  end

  // address and data survive reset undefined
  always_ff @(posedge clk) begin
    if (rst) begin
      q           <= d;
      q.mwe       <= 1'b0;
      q.mwe_cnt   <= 3'h0;
      q.we        <= 1'b0;
      q.timer     <= 22'h0;
      q.stall_cnt <= 3'h0;
    end else if (ce) begin
      q <= d;
    end
  end

  property p_read_stall;
    @(posedge clk) disable iff (rst)
      (ce && rd_go) ##1 ce[*5] |-> $past(stall, 4) && $past(stall) && !stall;
  endproperty
  a_read_stall: assert property (p_read_stall) else $error("read stall not four cycles");

  property p_mwe_window;
    @(posedge clk) disable iff (rst) (ce && $rose(q.mwe) && !io_wr) ##1 (ce && !io_wr)[*4] |-> !q.mwe;
  endproperty
  a_mwe_window: assert property (p_mwe_window) else $error("master enable not cleared");

  property p_addr_frozen;
    @(posedge clk) disable iff (rst) (ce && q.we) |=> q.addr == $past(q.addr);
  endproperty
  a_addr_frozen: assert property (p_addr_frozen) else $error("address moved during write");

endmodule

// [verif/ext_sram_model.sv]
// external sram model on the far side of the decoder
// assumes active-low strobes with address and data held while low
`timescale 1ns/1ps
module ext_sram_model (
  // clock
  input  wire logic        clk,
  // external bus
  input  wire logic [15:0] ext_addr,
  input  wire logic [7:0]  ext_wdata,
  input  wire logic        external_read_strobe_pin_n,
  input  wire logic        external_write_strobe_pin_n,
  output logic      [7:0]  ext_rdata
);
  logic [7:0] mem_q [256];
  logic [7:0] junk_q = 8'h00;
  ////////////////////////////////////////////////////////////////////////////////
  // low byte only: enough for the few locations the bench touches
  always_ff @(posedge clk) begin
    junk_q <= junk_q + 8'h3B;
    if (!external_write_strobe_pin_n) begin
      mem_q[ext_addr[7:0]] <= ext_wdata;
    end
  end
  // released bus shows a moving pattern, never the last byte
  assign ext_rdata = external_read_strobe_pin_n ? junk_q : mem_q[ext_addr[7:0]];
endmodule

// [verif/memspace_decode_test.sv]
// self-checking bench of the data-space decoder
// assumes the external sram model and a short nvm write time
`timescale 1ns/1ps
module memspace_decode_test;
  import memspace_pkg::*;
  typedef struct packed {
    logic l; logic [1:0] ws; logic w; logic [15:0] a; logic [7:0] d; region_t r; logic [3:0] n;
  } row_t;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, legacy_mode = 1'b0, pc_advance = 1'b0;
  logic pc_two_word = 1'b0, pc_load = 1'b0, boot_lock = 1'b1, app_lock = 1'b0;
  logic prog_wr_req = 1'b0, req_valid = 1'b0, external_memory_enable, pc_in_boot;
  logic prog_wr_allowed, req_ready, done, cpu_stall, ptr_wb_valid, periph_we, periph_re;
  logic external_read_strobe_pin_n, external_write_strobe_pin_n;
  logic [1:0] wait_states = 2'h0;
  logic [12:0] pc_target = 13'h0000, prog_wr_addr = 13'h0000, program_counter;
  logic [15:0] ptr_x = 16'h0000, ptr_y = 16'h0000, ptr_z = 16'h0000, ptr_wb_value, ext_addr;
  logic [7:0] periph_rdata = 8'h5A, rdata, periph_addr, periph_wdata, ext_wdata, ext_rdata;
  req_t req = '0;
  ptr_sel_t ptr_wb_sel;
  region_t periph_region;
  kind_t knd = K_BYTE;
  addr_mode_t am = AM_DIRECT;
  ptr_sel_t ps = PTR_X;
  logic sio = 1'b0;
  logic [5:0] dsp = 6'h00;
  int fail_count = 0, num_checks = 0, cyc = 0, n, s;
  row_t rows [12] = '{
    '{0, 0, 1, 16'h0055, 8'h80, RG_IO, 2}, '{0, 0, 1, 16'h04FF, 8'h3C, RG_SRAM, 2},
    '{0, 0, 0, 16'h04FF, 8'h3C, RG_SRAM, 2}, '{0, 0, 1, 16'h0500, 8'hA5, RG_EXT, 3},
    '{0, 1, 0, 16'h0500, 8'hA5, RG_EXT, 4}, '{0, 3, 0, 16'h0500, 8'hA5, RG_EXT, 6},
    '{0, 0, 0, 16'h0080, 8'h5A, RG_XIO, 2}, '{0, 0, 0, 16'h0010, 8'h5A, RG_RF, 2},
    '{1, 0, 1, 16'h0080, 8'h77, RG_SRAM, 2}, '{1, 0, 0, 16'h0080, 8'h77, RG_SRAM, 2},
    '{1, 0, 1, 16'h0460, 8'h11, RG_EXT, 3}, '{1, 2, 0, 16'h0460, 8'h11, RG_EXT, 5}};
  memspace_decode #(.NVM_WRITE_CLKS(50)) u_dut (.clk, .rst, .ce, .legacy_mode, .wait_states,
    .external_memory_enable, .pc_advance, .pc_two_word, .pc_load, .pc_target, .boot_lock,
    .app_lock, .prog_wr_req, .prog_wr_addr, .program_counter, .pc_in_boot, .prog_wr_allowed,
    .req_valid, .req, .ptr_x, .ptr_y, .ptr_z, .req_ready, .done, .rdata, .cpu_stall,
    .ptr_wb_valid, .ptr_wb_sel, .ptr_wb_value, .periph_region, .periph_addr, .periph_wdata,
    .periph_we, .periph_re, .periph_rdata, .ext_addr, .ext_wdata, .ext_rdata,
    .external_read_strobe_pin_n, .external_write_strobe_pin_n);
  ext_sram_model u_sram (.clk, .ext_addr, .ext_wdata, .ext_rdata,
    .external_read_strobe_pin_n, .external_write_strobe_pin_n);
  ////////////////////////////////////////////////////////////////////////////////
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // called at a falling edge; returns cycles to done and stall cycles after
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d, input logic ia);
    req = '{w, sio, knd, am, ps, dsp, a, d};
    req_valid = 1'b1;
    while (req_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    n = 1;
    s = 0;
    while (done !== 1'b1 && n < 40) begin
      if (ia) chk("strobes", {external_read_strobe_pin_n, external_write_strobe_pin_n}, 3);
      @(negedge clk);
      n++;
    end
    while (cpu_stall === 1'b1 && s < 9) begin
      @(negedge clk);
      s++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    chk("pc_reset", program_counter, 0);
    chk("xmem_reset", external_memory_enable, 0);
    pc_target = 13'h1BFE;
    pc_load = 1'b1;
    @(negedge clk);
    pc_load = 1'b0;
    pc_advance = 1'b1;
    pc_two_word = 1'b1;
    @(negedge clk);
    pc_advance = 1'b0;
    chk("pc", program_counter, 16'h1C00);
    chk("in_boot", pc_in_boot, 1);
    prog_wr_req = 1'b1;
    prog_wr_addr = 13'h1C00;
    #1 chk("boot_locked", prog_wr_allowed, 0);
    prog_wr_addr = 13'h0100;
    #1 chk("app_open", prog_wr_allowed, 1);
    @(negedge clk);
    prog_wr_req = 1'b0;
    acc(1'b0, 16'h0500, 8'h00, 1'b1);
    chk("unmapped_cycles", n, 2);
    chk("unmapped_data", rdata, 0);
    foreach (rows[i]) begin
      legacy_mode = rows[i].l;
      wait_states = rows[i].ws;
      acc(rows[i].w, rows[i].a, rows[i].d, rows[i].r != RG_EXT);
      chk("cycles", n, rows[i].n);
      chk("region", periph_region, rows[i].r);
      if (!rows[i].w) chk("rdata", rdata, rows[i].d);
    end
    chk("xmem_on", external_memory_enable, 1);
    acc(1'b1, 16'h003F, 8'hFF, 1'b1);
    acc(1'b0, 16'h003F, 8'h00, 1'b1);
    chk("addr_high", rdata, 8'h01);
    acc(1'b1, 16'h003E, 8'h34, 1'b1);
    acc(1'b1, 16'h003D, 8'hC7, 1'b1);
    acc(1'b1, 16'h003C, 8'h02, 1'b1);
    acc(1'b0, 16'h003C, 8'h00, 1'b1);
    chk("strobe_alone", rdata, 8'h00);
    acc(1'b1, 16'h003C, 8'h04, 1'b1);
    acc(1'b1, 16'h003C, 8'h02, 1'b1);
    chk("write_stall", s, 2);
    acc(1'b0, 16'h003C, 8'h00, 1'b1);
    chk("write_busy", rdata & 8'h02, 8'h02);
    acc(1'b1, 16'h003E, 8'h99, 1'b1);
    for (int k = 0; k < 40 && rdata[1] !== 1'b0; k++) acc(1'b0, 16'h003C, 8'h00, 1'b1);
    chk("write_end", rdata, 8'h00);
    acc(1'b1, 16'h003C, 8'h04, 1'b1);
    repeat (4) @(negedge clk);
    acc(1'b1, 16'h003C, 8'h02, 1'b1);
    acc(1'b0, 16'h003C, 8'h00, 1'b1);
    chk("window_shut", rdata, 8'h00);
    acc(1'b1, 16'h003D, 8'h00, 1'b1);
    acc(1'b1, 16'h003C, 8'h01, 1'b1);
    chk("read_stall", s, 4);
    acc(1'b0, 16'h003D, 8'h00, 1'b1);
    chk("read_data", rdata, 8'hC7);
    acc(1'b0, 16'h003E, 8'h00, 1'b1);
    chk("addr_kept", rdata, 8'h34);
    knd = K_FRAME_HEAD;
    acc(1'b0, 16'h0460, 8'h00, 1'b0);
    chk("frame_ws2", n, 9);
    wait_states = 2'h0;
    acc(1'b0, 16'h0460, 8'h00, 1'b0);
    chk("frame_ws0", n, 5);
    knd = K_FRAME_TAIL;
    acc(1'b0, 16'h0460, 8'h00, 1'b0);
    chk("frame_tail", n, 2);
    knd = K_BYTE;
    sio = 1'b1;
    acc(1'b0, 16'h00F5, 8'h00, 1'b1);
    chk("short_region", periph_region, RG_IO);
    chk("short_data", rdata, 8'h80);
    sio = 1'b0;
    legacy_mode = 1'b0;
    ptr_y = 16'h0200;
    ptr_z = 16'h04C0;
    am = AM_POSTINC;
    ps = PTR_Y;
    acc(1'b1, 16'h0000, 8'h6E, 1'b1);
    chk("wb_valid", ptr_wb_valid, 1);
    chk("wb_sel", ptr_wb_sel, PTR_Y);
    chk("wb_post", ptr_wb_value, 16'h0201);
    am = AM_PREDEC;
    acc(1'b1, 16'h0000, 8'h4D, 1'b1);
    chk("wb_pre", ptr_wb_value, 16'h01FF);
    am = AM_DISP;
    ps = PTR_Z;
    dsp = 6'h3F;
    acc(1'b0, 16'h0000, 8'h00, 1'b1);
    chk("disp", rdata, 8'h3C);
    chk("wb_none", ptr_wb_valid, 0);
    am = AM_DIRECT;
    acc(1'b0, 16'h0200, 8'h00, 1'b1);
    chk("post_addr", rdata, 8'h6E);
    report_and_stop();
  end
endmodule
